// ==== design/cca_top.sv ====
/*
 * Capture/compare array: one shared 16-bit counter and four modules
 * doing edge capture, software timer, toggle output or 6/7/8/10-bit PWM.
 * Assumes an Avalon-MM master on core_clk and a counter tick enable
 * from the neighbouring clock-source logic on the same clock.
 */
`include "cca_defines.svh"

module cca_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        count_tick,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  module_pin_i,
    output logic      [3:0]  module_pin_o,
    output logic      [3:0]  module_pin_oe_n,
    output logic             irq_req
);

    // ==========================================================
    // functions
    // ==========================================================
    function automatic cca_pkg::cca_word_t cnt_sel(
        input logic [1:0]          sel,
        input cca_pkg::cca_count_t c
    );
        unique case (sel)
            2'b00: cnt_sel = {3'h0, c[7:0]};
            2'b01: cnt_sel = {4'h0, c[6:0]};
            2'b10: cnt_sel = {5'h0, c[5:0]};
            2'b11: cnt_sel = {1'b0, c[9:0]};
        endcase
    endfunction : cnt_sel

    function automatic cca_pkg::cca_word_t act_word(
        input cca_pkg::cca_pwm_s p,
        input logic [7:0]        l
    );
        unique case (p.pwm_width_select)
            2'b00: act_word = {2'h0, p.compare_msb_bit, l};
            2'b01: act_word = {3'h0, p.compare_msb_bit, l[6:0]};
            2'b10: act_word = {4'h0, p.compare_msb_bit, l[5:0]};
            2'b11: act_word = {p.compare_msb_bit,
                               p.compare_extension_bits, l};
        endcase
    endfunction : act_word

    function automatic logic [7:0] reload_mask(input logic [1:0] sel);
        unique case (sel)
            2'b00: reload_mask = 8'hff;
            2'b01: reload_mask = 8'h7f;
            2'b10: reload_mask = 8'h3f;
            2'b11: reload_mask = 8'hff;
        endcase
    endfunction : reload_mask

    // register index of module k within a bank of four
    function automatic logic idx_is(
        input logic [7:0] i,
        input logic [7:0] base,
        input int         k
    );
        idx_is = (i == 8'(int'(base) + k));
    endfunction : idx_is

    // ==========================================================
    // bus decode
    // ==========================================================
    logic                    run_r;
    logic [3:0]              flag_r;
    cca_pkg::cca_count_t     cnt_r;
    logic                    cnt_moved_r;
    cca_pkg::cca_mode_s      mode_r [4];
    cca_pkg::cca_pwm_s       pwm_r  [4];
    logic [7:0]              capl_r [4];
    logic [7:0]              caph_r [4];
    logic [3:0]              pin_s2_r;
    logic [3:0]              pin_s3_r;

    wire logic [7:0] idx     = avs_address[9:2];
    wire logic [7:0] wbyte   = avs_writedata[7:0];
    wire logic       req     = avs_read | avs_write;
    // a write lands only at the edge where waitrequest is seen low
    wire logic       wr_fire = avs_write & ~avs_waitrequest
                               & avs_byteenable[0];
    wire logic       wr_ctrl = wr_fire & (idx == `CCA_IDX_CTRL);
    wire logic       wr_cl   = wr_fire & (idx == `CCA_IDX_CNT_LO);
    wire logic       wr_chi  = wr_fire & (idx == `CCA_IDX_CNT_HI);
    wire logic       tick    = run_r & count_tick;

    logic [3:0] wr_mode;
    logic [3:0] wr_capl;
    logic [3:0] wr_caph;
    logic [3:0] wr_pwm;
    logic [3:0] cap_hit;
    logic [3:0] match_hit;
    logic [3:0] tog_on;
    logic [3:0] pwm_on;
    logic [3:0] pwm_hi;
    logic [3:0] wrap;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [7:0] rd_mod [4];
    logic [3:0] pin_o_nxt;
    logic [3:0] oe_n_nxt;

    // pin synchroniser; first stage feeds only the second
    logic [3:0] pin_s1_full_r;
    // edges count only once all stages hold real pin levels, so
    // the reset value of the stages never shows up as an edge
    logic [2:0] arm_r;
    wire logic  armed = arm_r[2];
    assign rise     = {4{armed}} & pin_s2_r & ~pin_s3_r;
    assign fall     = {4{armed}} & ~pin_s2_r & pin_s3_r;

    // ==========================================================
    // per-module decode
    // ==========================================================
    genvar n;
    generate
        for (n = 0; n < `CCA_NUM_MODULES; n++) begin : g_mod
            wire cca_pkg::cca_mode_s m = mode_r[n];
            wire logic match_on = m.comparator_enable & m.match_enable;
            wire logic sel_mode = idx_is(idx, `CCA_IDX_MODE0, n);
            wire logic sel_capl = idx_is(idx, `CCA_IDX_CAPL0, n);
            wire logic sel_caph = idx_is(idx, `CCA_IDX_CAPH0, n);
            wire logic sel_pwm  = idx_is(idx, `CCA_IDX_PWM0, n);
            assign wr_mode[n] = wr_fire & sel_mode;
            assign wr_capl[n] = wr_fire & sel_capl;
            assign wr_caph[n] = wr_fire & sel_caph;
            assign wr_pwm[n]  = wr_fire & sel_pwm;
            // one module's byte, zero when none of its registers is hit
            assign rd_mod[n] = sel_mode ? {1'b0, m[6:0]}
                             : sel_capl ? capl_r[n]
                             : sel_caph ? caph_r[n]
                             : sel_pwm  ? pwm_r[n]
                             : 8'h00;
            assign cap_hit[n] = (m.rising_capture_enable & rise[n])
                | (m.falling_capture_enable & fall[n]);
            // match only on a fresh counter value
            assign match_hit[n] = match_on & cnt_moved_r
                & (cnt_r == {caph_r[n], capl_r[n]});
            // toggle mode needs all three enables
            assign tog_on[n] = match_on & m.toggle_output_enable;
            // pwm needs pwm and comparator enables
            assign pwm_on[n] = m.comparator_enable & m.pwm_output_enable;
            assign pwm_hi[n] = cnt_sel(pwm_r[n].pwm_width_select, cnt_r)
                >= act_word(pwm_r[n], capl_r[n]);
            // wrap seen as next value zero
            assign wrap[n] = pwm_on[n] & tick
                & (cnt_sel(pwm_r[n].pwm_width_select,
                           16'(cnt_r + 16'h0001)) == 11'h000);
        end
    endgenerate

    // ==========================================================
    // read mux
    // ==========================================================
    // index decodes never overlap, so the sources can be ored
    wire logic [7:0] rd_top =
        (idx == `CCA_IDX_CTRL)   ? {1'b0, run_r, 2'b00, flag_r} :
        (idx == `CCA_IDX_CNT_LO) ? cnt_r[7:0] :
        (idx == `CCA_IDX_CNT_HI) ? cnt_r[15:8] : 8'h00;
    wire logic [7:0] rd_byte = rd_top | rd_mod[0] | rd_mod[1]
                               | rd_mod[2] | rd_mod[3];

    // ==========================================================
    // bus slave: one wait cycle, then the answer
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            avs_readdata    <= {24'h00_0000, rd_byte};
        end
    end

    // ==========================================================
    // shared counter, control and flags
    // ==========================================================
    // set wins over a software clear; hardware never clears
    wire logic [3:0] flag_nxt = (cap_hit | match_hit)
        | (flag_r & (wr_ctrl ? wbyte[3:0] : 4'hf));
    wire cca_pkg::cca_count_t cnt_nxt =
        wr_cl  ? {cnt_r[15:8], wbyte} :
        wr_chi ? {wbyte, cnt_r[7:0]} :
        tick   ? 16'(cnt_r + 16'h0001) : cnt_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_r       <= 1'b0;
            flag_r      <= 4'h0;
            cnt_r       <= `CCA_RST_COUNT;
            cnt_moved_r <= 1'b0;
            irq_req     <= 1'b0;
        end else begin
            if (wr_ctrl)
                run_r <= wbyte[`CCA_CTRL_RUN_BIT];
            flag_r      <= flag_nxt;
            cnt_r       <= cnt_nxt;
            cnt_moved_r <= tick | wr_cl | wr_chi;
            // one shared request, gated per module
            irq_req <= |(flag_r & {mode_r[3].module_event_irq_enable,
                                   mode_r[2].module_event_irq_enable,
                                   mode_r[1].module_event_irq_enable,
                                   mode_r[0].module_event_irq_enable});
        end
    end

    // ==========================================================
    // pin sampling
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_s1_full_r <= 4'h0;
            pin_s2_r      <= 4'h0;
            pin_s3_r      <= 4'h0;
            arm_r         <= 3'h0;
        end else begin
            arm_r         <= {arm_r[1:0], 1'b1};
            pin_s1_full_r <= module_pin_i;
            pin_s2_r      <= pin_s1_full_r;
            pin_s3_r      <= pin_s2_r;
        end
    end

    // ==========================================================
    // module registers and outputs
    // ==========================================================
    // each module keeps its own configuration
    for (genvar k = 0; k < `CCA_NUM_MODULES; k++) begin : g_reg
        wire logic [1:0] wsel    = pwm_r[k].pwm_width_select;
        wire logic [7:0] rl_mask = reload_mask(wsel);
        // reload only the low bits that the width compares
        wire logic [7:0] capl_rl = (capl_r[k] & ~rl_mask)
                                   | (caph_r[k] & rl_mask);
        // capture beats a reload and a software write
        wire logic [7:0] capl_nxt = cap_hit[k] ? cnt_r[7:0]
                                  : wrap[k]    ? capl_rl
                                  : wr_capl[k] ? wbyte
                                  : capl_r[k];
        wire logic [7:0] caph_nxt = cap_hit[k] ? cnt_r[15:8]
                                  : wr_caph[k] ? wbyte
                                  : caph_r[k];
        wire cca_pkg::cca_pwm_s pwm_wr =
            wr_pwm[k] ? cca_pkg::cca_pwm_s'(wbyte) : pwm_r[k];
        // extension bits only in 10-bit width
        wire logic ext_ld = wrap[k] & (wsel == 2'b11);
        wire cca_pkg::cca_pwm_s pwm_nxt = '{
            pwm_width_select:       pwm_wr.pwm_width_select,
            reload_extension_bits:  pwm_wr.reload_extension_bits,
            compare_extension_bits: ext_ld
                ? pwm_r[k].reload_extension_bits
                : pwm_wr.compare_extension_bits,
            reload_msb_bit:         pwm_wr.reload_msb_bit,
            compare_msb_bit:        wrap[k]
                ? pwm_r[k].reload_msb_bit
                : pwm_wr.compare_msb_bit
        };
        // pwm level first, else toggle on match
        assign pin_o_nxt[k] = pwm_on[k] ? pwm_hi[k]
                            : (tog_on[k] & match_hit[k])
                            ? ~module_pin_o[k] : module_pin_o[k];
        // an idle module leaves its pin undriven
        assign oe_n_nxt[k] = ~(pwm_on[k] | tog_on[k]);

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                mode_r[k] <= `CCA_RST_BYTE;
                pwm_r[k]  <= `CCA_RST_BYTE;
                capl_r[k] <= `CCA_RST_BYTE;
                caph_r[k] <= `CCA_RST_BYTE;
            end else begin
                if (wr_mode[k])
                    mode_r[k] <= wbyte;
                pwm_r[k]  <= pwm_nxt;
                capl_r[k] <= capl_nxt;
                caph_r[k] <= caph_nxt;
            end
        end
    end

    // pins are registered together so each output is one flip-flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            module_pin_o    <= 4'h0;
            module_pin_oe_n <= 4'hf;
        end else begin
            module_pin_o    <= pin_o_nxt;
            module_pin_oe_n <= oe_n_nxt;
        end
    end

endmodule : cca_top

// ==== shared/cca_defines.svh ====
/*
 * Register indices, field positions and reset values of the
 * capture/compare array. Assumes a word-addressed register map where
 * the byte address on the bus is four times the register index.
 */
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

`define CCA_NUM_MODULES   4
`define CCA_IDX_CTRL      8'hd8
`define CCA_IDX_MODE0     8'hda
`define CCA_IDX_CNT_LO    8'he9
`define CCA_IDX_CAPL0     8'hea
`define CCA_IDX_PWM0      8'hf2
`define CCA_IDX_CNT_HI    8'hf9
`define CCA_IDX_CAPH0     8'hfa
`define CCA_CTRL_RUN_BIT  6
`define CCA_RST_BYTE      8'h00
`define CCA_RST_COUNT     16'h0000

`endif

// ==== shared/cca_pkg.sv ====
/*
 * Types of the capture/compare array: mode and PWM configuration
 * bytes and the counter and compare word types.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cca_pkg;

    typedef struct packed {
        logic unused7;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_enable;
        logic toggle_output_enable;
        logic pwm_output_enable;
        logic module_event_irq_enable;
    } cca_mode_s;

    typedef struct packed {
        logic [1:0] pwm_width_select;
        logic [1:0] reload_extension_bits;
        logic [1:0] compare_extension_bits;
        logic       reload_msb_bit;
        logic       compare_msb_bit;
    } cca_pwm_s;

    typedef logic [15:0] cca_count_t;
    typedef logic [10:0] cca_word_t;

endpackage : cca_pkg

// ==== bench/cca_pins.sv ====
/*
 * Far-side model of the four module pins.
 * Assumes the bench drives a pin only where drv_en is set.
 */
module cca_pins (
    input  wire logic       core_clk,
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] drv,
    input  wire logic [3:0] drv_en,
    output logic      [3:0] pin_lvl
);
    // ==========================================
    // wire level
    logic [3:0] last_r = 4'h0;

    always_ff @(posedge core_clk) begin
        last_r <= pin_lvl;
    end

    // no pull on these pins, so a released line wanders every cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pin_oe_n[i])
                pin_lvl[i] = pin_o[i];
            else if (drv_en[i])
                pin_lvl[i] = drv[i];
            else
                pin_lvl[i] = ~last_r[i];
        end
    end
endmodule : cca_pins

// ==== bench/cca_top_chk.sv ====
/*
 * Port checker of the capture/compare array.
 * Assumes it is bound onto every cca_top instance.
 */
module cca_top_chk (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        count_tick,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  module_pin_i,
    input wire logic [3:0]  module_pin_o,
    input wire logic [3:0]  module_pin_oe_n,
    input wire logic        irq_req
);
    // ==========================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic wr_done;
    assign wr_done = avs_write && !avs_waitrequest;

    wait_pulse_a: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("long ack");
    req_ack_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not acknowledged");
    idle_wait_a: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("ack without request");
    upper_zero_a: assert property (
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    top_bit_a: assert property (
        avs_read && !avs_waitrequest &&
        avs_address[9:2] inside {8'hd8, [8'hda:8'hdd]}
        |-> !avs_readdata[7]) else $error("unused bit reads one");
    // flags only leave by a software write
    irq_clear_a: assert property (
        $fell(irq_req) |-> $past(wr_done) || $past(wr_done, 2) ||
        $past(wr_done, 3)) else $error("irq dropped by hardware");
    oe_change_a: assert property (
        $changed(module_pin_oe_n) |-> $past(wr_done) ||
        $past(wr_done, 2)) else $error("pin enable moved alone");
    reset_state_a: assert property (disable iff (1'b0)
        !rst_n |=> module_pin_oe_n == 4'hf && module_pin_o == 4'h0 &&
        !irq_req && avs_waitrequest && avs_readdata == 32'h0)
        else $error("reset state wrong");

    cover property ($rose(irq_req));
    cover property ($changed(module_pin_o));
    cover property ($fell(module_pin_oe_n[3]));
endmodule : cca_top_chk

bind cca_top cca_top_chk chk_i (.*);

// ==== bench/testbench.sv ====
/*
 * Self-checking bench of cca_top: register accesses over the bus
 * and timer, toggle, capture and PWM scenarios.
 * Assumes the pin model cca_pins and the bound checker.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; $display("unexpected at %0t: %h vs %h", $time, g, e); \
    end end
    logic        core_clk = 1'b0, rst_n = 1'b0, count_tick = 1'b1;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_address = 10'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h1, drv = 4'h4, drv_en = 4'h4;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, irq_req;
    wire  [3:0]  pin_lvl, module_pin_o, module_pin_oe_n;
    int          err_count = 0, tests_run = 0;
    logic [7:0]  rv;
    logic [7:0]  ri [8] = '{8'hd8, 8'hda, 8'he9, 8'hea, 8'hf2, 8'hf9,
                            8'hfa, 8'hf5};
    logic [7:0]  pw [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    logic [7:0]  ph [4] = '{8'h01, 8'h00, 8'h00, 8'h04};
    logic [7:0]  pl [4] = '{8'h1f, 8'h9f, 8'h5f, 8'h1f};

    cca_top DUT (.module_pin_i(pin_lvl), .*);
    cca_pins pins (.core_clk, .pin_o(module_pin_o),
                   .pin_oe_n(module_pin_oe_n), .drv, .drv_en, .pin_lvl);

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // ==========================================
    // tasks
    task wrap_up;
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rv = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            err_count++;
            wrap_up();
        end
    endtask : acc

    task wr(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, i, d);
    endtask : wr

    task rc(input logic [7:0] i, input logic [7:0] e);
        acc(1'b0, i, 8'h00);
        `CHK(rv, e)
    endtask : rc

    task pwm(input logic [7:0] hi, input logic [7:0] lo, input logic e);
        wr(8'hf9, hi);
        wr(8'he9, lo);
        repeat (3) @(posedge core_clk);
        `CHK(module_pin_o[3], e)
    endtask : pwm

    // ==========================================
    // scenarios
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rc(ri[i], 8'h00);
        wr(8'h10, 8'h55);
        rc(8'h10, 8'h00);
        wr(8'hdd, 8'hff);
        rc(8'hdd, 8'h7f);
        rc(8'hdc, 8'h00);
        avs_byteenable <= 4'h0;
        wr(8'hdd, 8'h00);
        avs_byteenable <= 4'h1;
        rc(8'hdd, 8'h7f);
        wr(8'hdd, 8'h00);
        wr(8'hd8, 8'h00);
        wr(8'hea, 8'h34);
        wr(8'hfa, 8'h12);
        wr(8'hda, 8'h49);
        wr(8'hf9, 8'h12);
        wr(8'he9, 8'h34);
        rc(8'hd8, 8'h01);
        `CHK(irq_req, 1'b1)
        repeat (20) @(posedge core_clk);
        rc(8'hd8, 8'h01);
        wr(8'hd8, 8'h0e);
        rc(8'hd8, 8'h00);
        `CHK(irq_req, 1'b0)
        wr(8'hda, 8'h48);
        wr(8'he9, 8'h33);
        wr(8'he9, 8'h34);
        rc(8'hd8, 8'h01);
        `CHK(irq_req, 1'b0)
        wr(8'hd8, 8'h00);
        wr(8'hda, 8'h00);
        wr(8'heb, 8'h05);
        wr(8'hfb, 8'h00);
        wr(8'hdb, 8'h4c);
        wr(8'hf9, 8'h00);
        wr(8'he9, 8'h05);
        repeat (2) @(posedge core_clk);
        `CHK(module_pin_oe_n[1], 1'b0)
        `CHK(module_pin_o[1], 1'b1)
        wr(8'he9, 8'h04);
        wr(8'he9, 8'h05);
        repeat (2) @(posedge core_clk);
        `CHK(module_pin_o[1], 1'b0)
        wr(8'hdb, 8'h44);
        wr(8'he9, 8'h04);
        wr(8'he9, 8'h05);
        repeat (2) @(posedge core_clk);
        `CHK(module_pin_o[1], 1'b0)
        wr(8'hdb, 8'h00);
        wr(8'hd8, 8'h00);
        wr(8'hf9, 8'hab);
        wr(8'he9, 8'hcd);
        wr(8'hdc, 8'h20);
        drv[2] <= 1'b0;
        repeat (5) @(posedge core_clk);
        rc(8'hd8, 8'h00);
        drv[2] <= 1'b1;
        repeat (5) @(posedge core_clk);
        rc(8'hec, 8'hcd);
        rc(8'hfc, 8'hab);
        rc(8'hd8, 8'h04);
        wr(8'hd8, 8'h00);
        wr(8'hdc, 8'h10);
        wr(8'he9, 8'h11);
        drv[2] <= 1'b0;
        repeat (5) @(posedge core_clk);
        rc(8'hec, 8'h11);
        rc(8'hd8, 8'h04);
        wr(8'hdc, 8'h00);
        wr(8'hed, 8'h20);
        wr(8'hdd, 8'h02);
        repeat (2) @(posedge core_clk);
        `CHK(module_pin_oe_n[3], 1'b1)
        wr(8'hdd, 8'h42);
        // each width picks its counter bits
        for (int i = 0; i < 4; i++) begin
            wr(8'hf5, pw[i]);
            pwm(ph[i], pl[i], 1'b0);
            pwm(ph[i], pl[i] + 8'h01, 1'b1);
        end
        `CHK(module_pin_oe_n[3], 1'b0)
        count_tick <= 1'b0;
        wr(8'he9, 8'h00);
        wr(8'hd8, 8'h40);
        repeat (4) @(posedge core_clk);
        rc(8'he9, 8'h00);
        count_tick <= 1'b1;
        repeat (5) @(posedge core_clk);
        count_tick <= 1'b0;
        rc(8'he9, 8'h05);
        count_tick <= 1'b1;
        wr(8'hd8, 8'h00);
        wr(8'hf5, 8'hd0);
        wr(8'hfd, 8'h00);
        wr(8'hf9, 8'h00);
        wr(8'he9, 8'h00);
        wr(8'hd8, 8'h40);
        repeat (1100) @(posedge core_clk);
        wr(8'hd8, 8'h00);
        pwm(8'h00, 8'hff, 1'b0);
        pwm(8'h01, 8'h00, 1'b1);
        wr(8'hf5, 8'h02);
        wr(8'hfd, 8'h10);
        wr(8'he9, 8'hf0);
        wr(8'hd8, 8'h40);
        repeat (40) @(posedge core_clk);
        wr(8'hd8, 8'h00);
        pwm(8'h00, 8'hff, 1'b0);
        wrap_up();
    end
endmodule : testbench
